// ==== hw/aim_defines.svh ====
// register offsets, field positions, reset values and link timing counts
`ifndef AIM_DEFINES_SVH
`define AIM_DEFINES_SVH

// register offsets on the register port
`define AIM_OFF_CH0_WRITE_BYTE 8'h06
`define AIM_OFF_CH1_TARGET 8'h07
`define AIM_OFF_CH1_START_REG 8'h08
`define AIM_OFF_CH1_CONTROL 8'h09
`define AIM_OFF_CH1_WRITE_BYTE 8'h0A
`define AIM_OFF_CH2_TARGET 8'h0B
`define AIM_OFF_CH2_START_REG 8'h0C

// every register resets to the same value
`define AIM_REG_RESET 8'h00

// target register fields
`define AIM_DIR_BIT 7
`define AIM_ADDR_MSB 6

// control register fields
`define AIM_ACTIVE_BIT 7
`define AIM_SWAP_BIT 6
`define AIM_SKIP_BIT 5
`define AIM_ALIGN_BIT 4
`define AIM_COUNT_MSB 3

// link timing: eight link-clock phases per bus bit
`define AIM_LAST_PHASE 3'h7
`define AIM_SAMPLE_PHASE 3'h6
`define AIM_ACK_BIT 4'h8

`endif

// ==== hw/aim_pkg.sv ====
// shared types of the auxiliary bus master
package aim_pkg;

	// link sequencer states, one-hot
	typedef enum logic [4:0] {
		LS_IDLE = 5'h01,
		LS_NEXT = 5'h02,
		LS_START = 5'h04,
		LS_BYTE = 5'h08,
		LS_STOP = 5'h10
	} aim_link_state_t;

	// which byte of a transaction is on the wire, one-hot
	typedef enum logic [3:0] {
		STG_ADDR = 4'h1,
		STG_REG = 4'h2,
		STG_WDATA = 4'h4,
		STG_RDATA = 4'h8
	} aim_stage_t;

endpackage : aim_pkg

// ==== hw/aim_sync.sv ====
// two-flop level synchroniser with synchronous clear
`timescale 1ns/1ps
module aim_sync #(
	parameter int WIDTH = 1 // bits to synchronise
) (
	input wire logic clk, // destination clock
	input wire logic clear, // synchronous clear, active high
	input wire logic [WIDTH-1:0] d, // asynchronous levels
	output logic [WIDTH-1:0] q // synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("aim_sync: WIDTH must be at least 1");
		end
	endgenerate

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (clear) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : aim_sync

// ==== hw/aim_swap_slot.sv ====
// destination slot of one received byte, with pair swapping
`timescale 1ns/1ps
module aim_swap_slot (
	input wire logic [7:0] base, // first slot of this channel
	input wire logic [3:0] idx, // byte index within transaction
	input wire logic [7:0] startReg, // first target register
	input wire logic align, // 0: pair ends odd, 1: pair ends even
	input wire logic swap, // swap complete pairs
	input wire logic [3:0] count, // bytes in transaction
	output logic [7:0] dest // slot for this byte
);
	logic [7:0] regAddr;
	logic pairStart;
	logic [7:0] straight;

	// (RULE9) pairs follow target register addresses, not slot numbers
	always_comb begin
		regAddr = startReg + {4'h0, idx};
		// (RULE12) alignment picks the pair start
		pairStart = (regAddr[0] == align);
		straight = base + {4'h0, idx};
		// (RULE8) unpaired first or last byte stays put
		if (swap && pairStart && ({1'b0, idx} + 5'h01 < {1'b0, count})) begin
			dest = straight + 8'h01;
		end else if (swap && !pairStart && idx != 4'h0) begin
			dest = straight - 8'h01;
		end else begin
			dest = straight;
		end
	end
endmodule : aim_swap_slot

// ==== hw/aim_aux_master.sv ====
// auxiliary bus master: channel registers, sequencer and link engine
`timescale 1ns/1ps
`include "aim_defines.svh"
// Functional notes
// (RULE1) a write channel sends its write-value register as the data byte.
// (RULE2) target bit 7 set means read, clear means write.
// (RULE3) target bits 6:0 are the bus address sent for that channel.
// (RULE4) the start-register setting is where the transfer begins.
// (RULE5) an active channel is read every sample period, else it is idle.
// (RULE6) channel 1 stores after the slots taken by channel 0.
// (RULE7) with swap set, both bytes of a complete pair trade places.
// (RULE8) an unpaired first or last byte is never swapped.
// (RULE9) pairs come from target register addresses, not slot numbers.
// (RULE10) without swap, bytes land in consecutive slots in read order.
// (RULE11) with skip set, no register address byte is sent.
// (RULE12) alignment 0 ends pairs on odd addresses, 1 on even addresses.
// (RULE13) the 4-bit count sets how many bytes are read.
// (RULE14) channel 0 always stores from slot 0.
// (RULE15) a read is start, addr+W, register, restart, addr+R, bytes, stop.
// (RULE16) channels are serviced in ascending order each sample period.
module aim_aux_master
	import aim_pkg::*;
#(
	parameter int SLOTS = 24 // external-sensor data slots
) (
	input wire logic clk, // register-side clock, 25 MHz
	input wire logic reset, // synchronous reset, active high
	input wire logic auxClk, // link clock, drives the bus engine
	input wire logic [7:0] regAddr, // register port address
	input wire logic [7:0] regWrData, // register port write data
	input wire logic regWrite, // register port write strobe
	output logic [7:0] regRdData, // data at regAddr, one cycle late
	input wire logic sampleTick, // one pulse per sample period
	input wire logic [7:0] ch0Target, // channel 0 direction and address
	input wire logic [7:0] ch0StartReg, // channel 0 first register
	input wire logic [7:0] ch0Control, // channel 0 control bits
	input wire logic [7:0] ch2Control, // channel 2 control bits
	input wire logic [7:0] ch2WriteValue, // channel 2 write byte
	input wire logic [7:0] slotRdIdx, // data slot to read
	output logic [7:0] slotRdData, // slot contents, one cycle late
	output logic auxBusy, // a sample period is in progress
	output logic auxNack, // last period saw a refused byte
	output logic sclOut, // clock pin drive level, always low
	output logic sclOe, // clock pin pulled low
	input wire logic sdaIn, // data pin level
	output logic sdaOut, // data pin drive level, always low
	output logic sdaOe // data pin pulled low
);
	generate
		if (SLOTS < 1 || SLOTS > 256) begin : g_bad_slots
			$error("aim_aux_master: SLOTS must be 1 to 256");
		end
	endgenerate
	// register-side state
	typedef struct packed {
		logic [7:0] ch0WriteValue;
		logic [7:0] ch1Target;
		logic [7:0] ch1StartReg;
		logic [7:0] ch1Control;
		logic [7:0] ch1WriteValue;
		logic [7:0] ch2Target;
		logic [7:0] ch2StartReg;
		logic [2:0][31:0] cfgHold;
		logic reqTgl;
		logic busy;
		logic byteSeen;
		logic [7:0] regRd;
		logic [7:0] slotRd;
		logic [SLOTS-1:0][7:0] slots;
	} aim_host_state_t;
	// link-side state
	typedef struct packed {
		aim_link_state_t st;
		logic [2:0] ph;
		logic [3:0] bitCnt;
		aim_stage_t stage;
		logic rd;
		logic [1:0] ch;
		logic [3:0] idx;
		logic [7:0] base;
		logic [7:0] shift;
		logic reqSeen;
		logic doneTgl;
		logic byteTgl;
		logic [7:0] outSlot;
		logic [7:0] outData;
		logic ackBad;
		logic nack;
		logic sclLow;
		logic sdaLow;
		logic [2:0][31:0] cfg;
	} aim_link_fields_t;
	aim_host_state_t h_q;
	aim_host_state_t h_d;
	aim_link_fields_t l_q;
	aim_link_fields_t l_d;
	logic linkReset;
	logic reqSync, sdaSync;
	logic doneSync, byteSync, nackSync;
	logic [7:0] slotDest;
	logic [31:0] cur;
	logic [7:0] tgt;
	logic [7:0] sreg;
	logic [7:0] ctl;
	logic [7:0] wv;
	logic [3:0] cnt;
	logic [7:0] adv;
	// reset reaches the link domain through its own synchroniser
	aim_sync #(.WIDTH(1)) u_rst_sync (
		.clk(auxClk),
		.clear(1'b0),
		.d(reset),
		.q(linkReset)
	);
	// request toggle and data pin into the link domain
	aim_sync #(.WIDTH(2)) u_link_sync (
		.clk(auxClk),
		.clear(linkReset),
		.d({h_q.reqTgl, sdaIn}),
		.q({reqSync, sdaSync})
	);
	// completion, byte toggle and refusal flag back to the register side
	aim_sync #(.WIDTH(3)) u_host_sync (
		.clk(clk),
		.clear(reset),
		.d({l_q.doneTgl, l_q.byteTgl, l_q.nack}),
		.q({doneSync, byteSync, nackSync})
	);
	// fields of the channel being serviced; channel 3 means all done
	always_comb begin
		cur = (l_q.ch == 2'h3) ? 32'h0000_0000 : l_q.cfg[l_q.ch];
		tgt = cur[31:24];
		sreg = cur[23:16];
		ctl = cur[15:8];
		wv = cur[7:0];
		cnt = ctl[`AIM_COUNT_MSB:0];
		// (RULE6) slots used by an active channel
		adv = ctl[`AIM_ACTIVE_BIT] ? {4'h0, cnt} : 8'h00;
	end
	// (RULE7) slot for the byte now in the shifter
	aim_swap_slot u_swap_slot (
		.base(l_q.base),
		.idx(l_q.idx),
		.startReg(sreg),
		.align(ctl[`AIM_ALIGN_BIT]),
		.swap(ctl[`AIM_SWAP_BIT]),
		.count(cnt),
		.dest(slotDest)
	);
	// register port, sample-period request and slot storage
	always_comb begin
		h_d = h_q;
		h_d.busy = (h_q.reqTgl != doneSync);
		if (regWrite) begin
			case (regAddr)
				`AIM_OFF_CH0_WRITE_BYTE: h_d.ch0WriteValue = regWrData;
				`AIM_OFF_CH1_TARGET: h_d.ch1Target = regWrData;
				`AIM_OFF_CH1_START_REG: h_d.ch1StartReg = regWrData;
				`AIM_OFF_CH1_CONTROL: h_d.ch1Control = regWrData;
				`AIM_OFF_CH1_WRITE_BYTE: h_d.ch1WriteValue = regWrData;
				`AIM_OFF_CH2_TARGET: h_d.ch2Target = regWrData;
				`AIM_OFF_CH2_START_REG: h_d.ch2StartReg = regWrData;
				default: ;
			endcase
		end
		// read data shows the stored value; unmapped offsets read zero
		case (regAddr)
			`AIM_OFF_CH0_WRITE_BYTE: h_d.regRd = h_q.ch0WriteValue;
			`AIM_OFF_CH1_TARGET: h_d.regRd = h_q.ch1Target;
			`AIM_OFF_CH1_START_REG: h_d.regRd = h_q.ch1StartReg;
			`AIM_OFF_CH1_CONTROL: h_d.regRd = h_q.ch1Control;
			`AIM_OFF_CH1_WRITE_BYTE: h_d.regRd = h_q.ch1WriteValue;
			`AIM_OFF_CH2_TARGET: h_d.regRd = h_q.ch2Target;
			`AIM_OFF_CH2_START_REG: h_d.regRd = h_q.ch2StartReg;
			default: h_d.regRd = 8'h00;
		endcase
		h_d.slotRd = (slotRdIdx < SLOTS) ? h_q.slots[slotRdIdx] : 8'h00;
		// (RULE5) snapshot stays frozen until the link reports done
		if (sampleTick && (h_q.reqTgl == doneSync)) begin
			h_d.cfgHold[0] = {ch0Target, ch0StartReg, ch0Control,
				h_q.ch0WriteValue};
			h_d.cfgHold[1] = {h_q.ch1Target, h_q.ch1StartReg,
				h_q.ch1Control, h_q.ch1WriteValue};
			h_d.cfgHold[2] = {h_q.ch2Target, h_q.ch2StartReg, ch2Control,
				ch2WriteValue};
			h_d.reqTgl = ~h_q.reqTgl;
		end
		// byte words are held by the link for a whole bus byte
		if (byteSync != h_q.byteSeen) begin
			h_d.byteSeen = byteSync;
			if (l_q.outSlot < SLOTS) begin
				h_d.slots[l_q.outSlot] = l_q.outData;
			end
		end
		if (reset) begin
			h_d = '0;
			h_d.ch0WriteValue = `AIM_REG_RESET;
			h_d.ch1Target = `AIM_REG_RESET;
			h_d.ch1StartReg = `AIM_REG_RESET;
			h_d.ch1Control = `AIM_REG_RESET;
			h_d.ch1WriteValue = `AIM_REG_RESET;
			h_d.ch2Target = `AIM_REG_RESET;
			h_d.ch2StartReg = `AIM_REG_RESET;
		end
	end
	// register-side flops
	always_ff @(posedge clk) begin
		h_q <= h_d;
	end
	// link sequencer: bits, bytes and channel order
	always_comb begin
		l_d = l_q;
		l_d.sclLow = 1'b0;
		l_d.sdaLow = 1'b0;
		case (l_q.st)
			LS_IDLE: begin
				if (reqSync != l_q.reqSeen) begin
					// cfgHold is stable while the request toggle is pending
					l_d.reqSeen = reqSync;
					l_d.cfg = h_q.cfgHold;
					l_d.nack = 1'b0;
					l_d.ch = 2'h0;
					// (RULE14) channel 0 starts at slot 0
					l_d.base = 8'h00;
					l_d.st = LS_NEXT;
				end
			end
			LS_NEXT: begin
				// (RULE16) ascending channel walk
				if (l_q.ch == 2'h3) begin
					l_d.doneTgl = ~l_q.doneTgl;
					l_d.st = LS_IDLE;
				end else if (ctl[`AIM_ACTIVE_BIT] &&
					!(tgt[`AIM_DIR_BIT] && cnt == 4'h0)) begin
					// (RULE11) skip phase reads straight away
					l_d.rd = tgt[`AIM_DIR_BIT] && ctl[`AIM_SKIP_BIT];
					l_d.idx = 4'h0;
					l_d.ph = 3'h0;
					l_d.st = LS_START;
				end else begin
					// (RULE5) inactive channel does nothing
					l_d.ch = l_q.ch + 2'h1;
					l_d.base = l_q.base + adv;
				end
			end
			LS_START: begin
				// (RULE15) start or repeated start
				l_d.sclLow = (l_q.ph[2:1] == 2'h0) || (l_q.ph[2:1] == 2'h3);
				l_d.sdaLow = l_q.ph[2];
				l_d.ph = l_q.ph + 3'h1;
				if (l_q.ph == `AIM_LAST_PHASE) begin
					l_d.st = LS_BYTE;
					l_d.bitCnt = 4'h0;
					l_d.stage = STG_ADDR;
					// (RULE3) address with direction bit
					l_d.shift = {tgt[`AIM_ADDR_MSB:0], l_q.rd};
				end
			end
			LS_BYTE: begin
				l_d.sclLow = (l_q.ph[2:1] == 2'h0) || (l_q.ph[2:1] == 2'h3);
				if (l_q.bitCnt != `AIM_ACK_BIT) begin
					l_d.sdaLow = (l_q.stage != STG_RDATA) && !l_q.shift[7];
				end else begin
					// (RULE15) acknowledge every read byte but the last
					l_d.sdaLow = (l_q.stage == STG_RDATA) &&
						({1'b0, l_q.idx} + 5'h01 != {1'b0, cnt});
				end
				l_d.ph = l_q.ph + 3'h1;
				if (l_q.ph == `AIM_SAMPLE_PHASE) begin
					if (l_q.bitCnt != `AIM_ACK_BIT) begin
						if (l_q.stage == STG_RDATA) begin
							l_d.shift = {l_q.shift[6:0], sdaSync};
						end
					end else begin
						l_d.ackBad = (l_q.stage != STG_RDATA) && sdaSync;
					end
				end
				if (l_q.ph == `AIM_LAST_PHASE) begin
					if (l_q.bitCnt != `AIM_ACK_BIT) begin
						l_d.bitCnt = l_q.bitCnt + 4'h1;
						if (l_q.stage != STG_RDATA) begin
							l_d.shift = {l_q.shift[6:0], 1'b0};
						end
					end else begin
						l_d.bitCnt = 4'h0;
						case (l_q.stage)
							STG_RDATA: begin
								// (RULE10) slot by index unless swapped
								l_d.outSlot = slotDest;
								l_d.outData = l_q.shift;
								l_d.byteTgl = ~l_q.byteTgl;
								l_d.idx = l_q.idx + 4'h1;
								// (RULE13) stop after count bytes
								if ({1'b0, l_q.idx} + 5'h01 == {1'b0, cnt}) begin
									l_d.st = LS_STOP;
								end
							end
							STG_ADDR: begin
								// a refused address ends the transaction
								if (l_q.ackBad) begin
									l_d.nack = 1'b1;
									l_d.st = LS_STOP;
								end else if (l_q.rd) begin
									l_d.stage = STG_RDATA;
								end else if (ctl[`AIM_SKIP_BIT]) begin
									// (RULE11) no register byte
									l_d.stage = STG_WDATA;
									l_d.shift = wv;
								end else begin
									// (RULE4) register address byte
									l_d.stage = STG_REG;
									l_d.shift = sreg;
								end
							end
							STG_REG: begin
								if (l_q.ackBad) begin
									l_d.nack = 1'b1;
									l_d.st = LS_STOP;
								end else if (tgt[`AIM_DIR_BIT]) begin
									// (RULE2) read turns around
									l_d.rd = 1'b1;
									l_d.ph = 3'h0;
									l_d.st = LS_START;
								end else begin
									// (RULE1) write value follows
									l_d.stage = STG_WDATA;
									l_d.shift = wv;
								end
							end
							default: begin
								l_d.nack = l_q.nack | l_q.ackBad;
								l_d.st = LS_STOP;
							end
						endcase
					end
				end
			end
			LS_STOP: begin
				l_d.sclLow = (l_q.ph[2:1] == 2'h0);
				l_d.sdaLow = !l_q.ph[2];
				l_d.ph = l_q.ph + 3'h1;
				if (l_q.ph == `AIM_LAST_PHASE) begin
					// (RULE6) next channel follows these slots
					l_d.ch = l_q.ch + 2'h1;
					l_d.base = l_q.base + adv;
					l_d.st = LS_NEXT;
				end
			end
			default: l_d.st = LS_IDLE;
		endcase
		if (linkReset) begin
			l_d = '0;
			l_d.st = LS_IDLE;
			l_d.stage = STG_ADDR;
		end
	end
	// link-side flops
	always_ff @(posedge auxClk) begin
		l_q <= l_d;
	end
	// open-drain pins: only ever pull low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = l_q.sclLow;
	assign sdaOe = l_q.sdaLow;
	assign regRdData = h_q.regRd;
	assign slotRdData = h_q.slotRd;
	assign auxBusy = h_q.busy;
	assign auxNack = nackSync;
endmodule : aim_aux_master

// ==== tb/aim_sensor_model.sv ====
// behavioural sensor target on the auxiliary bus
`timescale 1ns/1ps
module aim_sensor_model #(
	parameter logic [6:0] ADDR = 7'h2C // bus address, arbitrary
) (
	input wire logic scl, // clock line level
	input wire logic sda, // data line level
	output logic sdaOe // pulls data line low
);
	logic [7:0] mem [256];
	logic [7:0] rx [$];
	logic [7:0] sh, ptr;
	logic first, ok, pend, rd, regNext;
	int n;
	// register contents follow a fixed pattern
	initial begin
		sdaOe = 0;
		n = 0;
		{first, ok, pend, rd, regNext, sh, ptr} = '0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 11);
	end
	// start or stop restarts the frame
	always @(sda) if (scl === 1'b1) begin
		n = 0;
		first = 1;
		rd = 0;
		sdaOe = 0;
	end
	// sample bits; master ack advances the pointer
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		else if (rd && sda) rd = 0;
		else if (rd) ptr++;
		n++;
	end
	// ack bytes, auto-increment, drive read bits
	always @(negedge scl) begin
		if (n == 8 && !rd) begin
			if (first) begin
				ok = sh[7:1] == ADDR;
				pend = ok && sh[0];
				regNext = !sh[0];
			end else if (ok) begin
				rx.push_back(sh);
				if (regNext) ptr = sh;
				else mem[ptr++] = sh;
				regNext = 0;
			end
			first = 0;
			sdaOe = ok;
		end else if (n == 9) begin
			n = 0;
			rd = rd || pend;
			pend = 0;
			sdaOe = rd && !mem[ptr][7];
		end else if (rd) sdaOe = n < 8 && !mem[ptr][7 - n];
	end
endmodule : aim_sensor_model

// ==== tb/aim_aux_master_checker.sv ====
// port assertions for the auxiliary bus master
`timescale 1ns/1ps
module aim_aux_master_checker #(
	parameter int SLOTS = 24 // data slots
) (
	input wire logic clk, // register clock
	input wire logic reset, // sync reset
	input wire logic auxClk, // link clock
	input wire logic [7:0] regAddr, // offset
	input wire logic [7:0] regWrData, // write data
	input wire logic regWrite, // write strobe
	input wire logic [7:0] regRdData, // read data
	input wire logic sampleTick, // period start
	input wire logic [7:0] slotRdIdx, // slot index
	input wire logic [7:0] slotRdData, // slot data
	input wire logic auxBusy, // period running
	input wire logic sclOe, // clock pin low
	input wire logic sdaOe // data pin low
);
	// write to the target register, then address held
	sequence s_wr_target;
		regWrite && regAddr == 8'h07 ##1 !regWrite && regAddr == 8'h07;
	endsequence
	// one full high phase of the bus clock
	sequence s_scl_high;
		!sclOe [*4];
	endsequence
	a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
		(regAddr < 8'h06 || regAddr > 8'h0C) |=> regRdData == 8'h00)
		else $error("unmapped read nonzero");
	a_target_back: assert property (@(posedge clk) disable iff (reset)
		s_wr_target |=> regRdData == $past(regWrData, 2))
		else $error("target readback wrong");
	a_busy_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(auxBusy) |-> $past(sampleTick, 2))
		else $error("busy without tick");
	a_busy_holds: assert property (@(posedge clk) disable iff (reset)
		$rose(auxBusy) |-> auxBusy [*4])
		else $error("busy dropped early");
	a_slot_range: assert property (@(posedge clk) disable iff (reset)
		slotRdIdx >= SLOTS |=> slotRdData == 8'h00)
		else $error("slot beyond range nonzero");
	a_idle_free: assert property (@(posedge clk) disable iff (reset)
		!auxBusy [*8] |-> !sclOe && !sdaOe)
		else $error("pins held while idle");
	a_scl_width: assert property (@(posedge auxClk) disable iff (reset)
		$fell(sclOe) |-> s_scl_high)
		else $error("clock high phase short");
	a_scl_low: assert property (@(posedge auxClk) disable iff (reset)
		sclOe |-> ##[1:16] !sclOe)
		else $error("clock held low too long");
endmodule : aim_aux_master_checker
bind aim_aux_master aim_aux_master_checker #(.SLOTS(SLOTS)) chk (
	.clk(clk),
	.reset(reset),
	.auxClk(auxClk),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWrite(regWrite),
	.regRdData(regRdData),
	.sampleTick(sampleTick),
	.slotRdIdx(slotRdIdx),
	.slotRdData(slotRdData),
	.auxBusy(auxBusy),
	.sclOe(sclOe),
	.sdaOe(sdaOe)
);

// ==== tb/aux_i2c_master_slave_channels_test.sv ====
// self-checking bench for the auxiliary bus master channels
`timescale 1ns/1ps
module aux_i2c_master_slave_channels_test;
	localparam logic [6:0] TA = 7'h2C; // sensor address, arbitrary
	logic clk, reset, auxClk, regWrite, sampleTick, auxBusy, auxNack;
	logic sclOut, sclOe, sdaOut, sdaOe, tgtOe, scl, sda;
	logic [7:0] regAddr, regWrData, regRdData, ch0Target, ch0StartReg;
	logic [7:0] ch0Control, ch2Control, ch2WriteValue, slotRdIdx;
	logic [7:0] slotRdData, r, ctl;
	logic [7:0] q [$];
	int err_total, total_checks, seed, i, k;
	// open-drain lines with pull-ups
	assign scl = !sclOe;
	assign sda = !(sdaOe || tgtOe);
	aim_aux_master dut (
		.clk(clk),
		.reset(reset),
		.auxClk(auxClk),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRdData(regRdData),
		.sampleTick(sampleTick),
		.ch0Target(ch0Target),
		.ch0StartReg(ch0StartReg),
		.ch0Control(ch0Control),
		.ch2Control(ch2Control),
		.ch2WriteValue(ch2WriteValue),
		.slotRdIdx(slotRdIdx),
		.slotRdData(slotRdData),
		.auxBusy(auxBusy),
		.auxNack(auxNack),
		.sclOut(sclOut),
		.sclOe(sclOe),
		.sdaIn(sda),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe)
	);
	aim_sensor_model #(.ADDR(TA)) tgt (.scl(scl), .sda(sda), .sdaOe(tgtOe));
	// register clock
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// link clock, phase unrelated
	initial begin
		auxClk = 0;
		#7;
		forever #62.5 auxClk = ~auxClk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		total_checks++;
		if (got !== want) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	// one register write, strobe dropped for a cycle after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1;
		step(1);
		regWrite = 0;
		step(1);
	endtask : wr
	task automatic rr(input logic [7:0] a, input logic [7:0] want);
		regAddr = a;
		step(2);
		check(regRdData, want);
	endtask : rr
	task automatic sl(input int j, input logic [7:0] want);
		slotRdIdx = 8'(j);
		step(2);
		check(slotRdData, want);
	endtask : sl
	// relative slot of byte m, pairs set by target register address
	function automatic int dst(input int m, input logic [7:0] c,
		input logic [7:0] s);
		logic [7:0] a;
		a = s + 8'(m);
		if (c[6] && a[0] == c[4] && m + 1 < int'(c[3:0])) return m + 1;
		if (c[6] && a[0] != c[4] && m > 0) return m - 1;
		return m;
	endfunction : dst
	task automatic chan(input int b, input logic [7:0] s, input logic [7:0] c);
		for (int m = 0; m < int'(c[3:0]); m++)
			sl(b + dst(m, c, s), tgt.mem[8'(s + m)]);
	endtask : chan
	// one sample period; a second tick mid-period must be dropped
	task automatic per(input bit dbl);
		sampleTick = 1;
		step(1);
		sampleTick = 0;
		step(20);
		sampleTick = dbl;
		step(1);
		sampleTick = 0;
		k = 0;
		while (auxBusy !== 1'b0 && k < 50000) begin
			step(1);
			k++;
		end
		check({7'h0, auxBusy}, 8'h00);
		step(4);
	endtask : per
	task automatic run(input logic [7:0] s0, input logic [7:0] c0,
		input logic [7:0] s1, input logic [7:0] c1);
		ch0Target = {1'b1, TA};
		ch0StartReg = s0;
		ch0Control = c0;
		wr(8'h07, {1'b1, TA});
		wr(8'h08, s1);
		wr(8'h09, c1);
		per(0);
		check({7'h0, auxNack}, 8'h00);
		if (c0[7]) chan(0, s0, c0);
		chan(c0[7] ? int'(c0[3:0]) : 0, s1, c1);
	endtask : run
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	// watchdog against a stuck period
	initial begin
		#4000000;
		err_total++;
		results();
	end
	// main sequence
	initial begin
		seed = 20883;
		err_total = 0;
		total_checks = 0;
		{reset, regWrite, sampleTick} = 3'b100;
		{regAddr, regWrData, ch0Target, ch0StartReg} = '0;
		{ch0Control, ch2Control, ch2WriteValue, slotRdIdx} = '0;
		step(12); // link reset lands within three link clocks
		reset = 0;
		step(20);
		check({6'h0, sclOut, sdaOut}, 8'h00);
		for (i = 6; i < 14; i++) rr(8'(i), 8'h00);
		sl(255, 8'h00);
		for (i = 6; i < 14; i++) begin
			r = 8'($random(seed));
			wr(8'(i), r);
			rr(8'(i), i == 13 ? 8'h00 : r);
		end
		$display("registers done");
		wr(8'h07, 8'hD5);
		wr(8'h09, 8'h82);
		per(0);
		check({7'h0, auxNack}, 8'h01);
		$display("nack done");
		// writes on channels 1 and 2, extra tick refused
		for (i = 0; i < 2; i++) begin
			r = 8'($random(seed));
			wr(8'h07, {1'b0, TA});
			wr(8'h08, r);
			wr(8'h0A, ~r);
			wr(8'h09, {2'b10, i[0], 5'h01});
			wr(8'h0B, {1'b0, TA});
			wr(8'h0C, r ^ 8'h3C);
			ch2Control = 8'h81;
			ch2WriteValue = r + 8'h01;
			tgt.rx.delete();
			per(1);
			q = {r, ~r, r ^ 8'h3C, r + 8'h01};
			if (i == 1) q.delete(0);
			check(8'(tgt.rx.size()), 8'(q.size()));
			foreach (q[j]) check(tgt.rx[j], q[j]);
		end
		ch2Control = 8'h00;
		$display("writes done");
		wr(8'h07, {1'b1, TA});
		wr(8'h09, 8'hA2);
		tgt.rx.delete();
		ctl = tgt.ptr;
		per(0);
		check(8'(tgt.rx.size()), 8'h00);
		chan(0, ctl, 8'hA2);
		run(8'h10, 8'h83, 8'h01, 8'hC4);
		for (i = 0; i < 5; i++) begin
			ctl = 8'($random(seed));
			ctl[5] = 0;
			ctl[3:0] = {1'b0, ctl[2:0]} + 4'h1;
			r = 8'($random(seed));
			r[7] = 1;
			r[5] = 0;
			if (r[3:0] == 4'h0) r[3:0] = 4'h9;
			run(8'($random(seed)), ctl, 8'($random(seed)), r);
		end
		$display("reads done");
		results();
	end
endmodule : aux_i2c_master_slave_channels_test
